// >>> hdl/hub_ind_defines.svh
`ifndef HUB_IND_DEFINES_SVH
`define HUB_IND_DEFINES_SVH

// ==========================================
// sizes and encodings
`define NUM_DN_PORTS 6
`define SPEED_NONE 2'h0
`define SPEED_FS_HS 2'h1
`define SPEED_SS 2'h2
`define SPEED_RSVD 2'h3
`define MGMT_ROLE_TARGET 1'h0
`define MGMT_ROLE_BRIDGE 1'h1
// worst indicator latency after a state change, in clocks
`define IND_LATENCY 2

`endif

// >>> hdl/hub_ind_pkg.sv
package hub_ind_pkg;
    typedef enum logic [1:0] {
        LINK_NONE,
        LINK_LEGACY,
        LINK_GEN1
    } link_rate_t;

    typedef enum logic {
        ROLE_TARGET,
        ROLE_BRIDGE
    } mgmt_role_t;

    typedef enum {
        HUB_RESET,
        HUB_RUN
    } hub_state_t;
endpackage : hub_ind_pkg

// >>> hdl/hub_port_status_indicators.sv
`timescale 1ns/1ps
`include "hub_ind_defines.svh"
// Function
// (R1) per port: float unattached, low for 2.0/1.1, high for Gen 1
// (R2) charging flag low after handshake, high before, when charging enabled
// (R3) charging flag floats on ports without charging enabled
// (R4) host link flag floats unattached, low Gen 1, high 2.0/1.1
// (R5) hub held in reset mode while reset input is low
// (R6) management pins act as target or bridge per configuration
// (R7) suspend flag output reflects 2.0 suspend for host wakeup
// (R8) straps latched at power-on and at each reset release
// (R9) indicators registered and updated within bounded cycles
module hub_port_status_indicators (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    // port, host and suspend state from the hub core
    input wire logic [11:0] PORT_RATE_I,
    input wire logic [5:0] PORT_CHARGE_EN_I,
    input wire logic [5:0] PORT_CHARGE_DONE_I,
    input wire logic [1:0] HOST_RATE_I,
    input wire logic SUSPEND_I,
    // strap input
    input wire logic MGMT_ROLE_STRAP_I,
    // management serial pins
    input wire logic MGMT_SERIAL_CLOCK_I,
    input wire logic MGMT_SERIAL_LINE_I,
    input wire logic TARGET_CLOCK_OE_I,
    input wire logic TARGET_LINE_OE_I,
    input wire logic BRIDGE_CLOCK_OE_I,
    input wire logic BRIDGE_LINE_OE_I,
    output logic MGMT_SERIAL_CLOCK_O,
    output logic MGMT_SERIAL_CLOCK_OE_O,
    output logic MGMT_SERIAL_LINE_O,
    output logic MGMT_SERIAL_LINE_OE_O,
    output logic TARGET_CLOCK_O,
    output logic TARGET_LINE_O,
    output logic BRIDGE_CLOCK_O,
    output logic BRIDGE_LINE_O,
    output hub_ind_pkg::mgmt_role_t MGMT_ROLE_O,
    // indicators
    output logic [5:0] PORT_LINK_RATE_FLAG_O,
    output logic [5:0] PORT_LINK_RATE_FLAG_OE_O,
    output logic [5:0] PORT_CHARGE_FLAG_O,
    output logic [5:0] PORT_CHARGE_FLAG_OE_O,
    output logic HOST_LINK_FLAG_O,
    output logic HOST_LINK_FLAG_OE_O,
    output logic SUSPEND_WAKE_FLAG_O,
    // hub reset mode
    output logic HUB_IN_RESET_O
);
    import hub_ind_pkg::*;

    // ==========================================
    // reset mode and strap capture
    hub_state_t state_r;
    mgmt_role_t role_r;
    wire strap_take = (state_r == HUB_RESET);

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_r <= HUB_RESET; // see R5
        end else begin
            case (state_r)
                HUB_RESET: state_r <= HUB_RUN;
                HUB_RUN: state_r <= HUB_RUN;
                default: state_r <= HUB_RESET;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            role_r <= ROLE_TARGET;
        end else if (strap_take) begin
            role_r <= mgmt_role_t'(MGMT_ROLE_STRAP_I); // see R8
        end
    end

    // ==========================================
    // indicator decode
    logic [5:0] rate_nxt;
    logic [5:0] rate_oe_nxt;
    always_comb begin
        for (int i = 0; i < `NUM_DN_PORTS; i++) begin
            rate_oe_nxt[i] = (PORT_RATE_I[2*i +: 2] != `SPEED_NONE); // see R1
            rate_nxt[i] = (PORT_RATE_I[2*i +: 2] == `SPEED_SS); // see R1
        end
    end
    wire [5:0] charge_nxt = ~PORT_CHARGE_DONE_I; // see R2
    wire [5:0] charge_oe_nxt = PORT_CHARGE_EN_I; // see R3
    wire host_oe_nxt = (HOST_RATE_I != `SPEED_NONE); // see R4
    wire host_nxt = (HOST_RATE_I == `SPEED_FS_HS); // see R4
    wire running = (state_r == HUB_RUN);

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PORT_LINK_RATE_FLAG_O <= 6'h00;
            PORT_LINK_RATE_FLAG_OE_O <= 6'h00;
            PORT_CHARGE_FLAG_O <= 6'h00;
            PORT_CHARGE_FLAG_OE_O <= 6'h00;
            HOST_LINK_FLAG_O <= 1'h0;
            HOST_LINK_FLAG_OE_O <= 1'h0;
            SUSPEND_WAKE_FLAG_O <= 1'h0;
            HUB_IN_RESET_O <= 1'h1;
        end else begin
            // registered, one clock behind inputs; see R9
            PORT_LINK_RATE_FLAG_O <= rate_nxt & {6{running}};
            PORT_LINK_RATE_FLAG_OE_O <= rate_oe_nxt & {6{running}};
            PORT_CHARGE_FLAG_O <= charge_nxt & {6{running}};
            PORT_CHARGE_FLAG_OE_O <= charge_oe_nxt & {6{running}};
            HOST_LINK_FLAG_O <= host_nxt & running;
            HOST_LINK_FLAG_OE_O <= host_oe_nxt & running;
            SUSPEND_WAKE_FLAG_O <= SUSPEND_I & running; // see R7
            HUB_IN_RESET_O <= ~running; // see R5
        end
    end

    // ==========================================
    // management pin routing
    wire is_bridge = (role_r == ROLE_BRIDGE);
    wire clk_oe_sel = is_bridge ? BRIDGE_CLOCK_OE_I : TARGET_CLOCK_OE_I; // see R6
    wire line_oe_sel = is_bridge ? BRIDGE_LINE_OE_I : TARGET_LINE_OE_I; // see R6

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            MGMT_SERIAL_CLOCK_OE_O <= 1'h0;
            MGMT_SERIAL_LINE_OE_O <= 1'h0;
            MGMT_SERIAL_CLOCK_O <= 1'h0;
            MGMT_SERIAL_LINE_O <= 1'h0;
            TARGET_CLOCK_O <= 1'h1;
            TARGET_LINE_O <= 1'h1;
            BRIDGE_CLOCK_O <= 1'h1;
            BRIDGE_LINE_O <= 1'h1;
            MGMT_ROLE_O <= ROLE_TARGET;
        end else begin
            // open drain: pins only ever pulled low
            MGMT_SERIAL_CLOCK_O <= 1'h0;
            MGMT_SERIAL_LINE_O <= 1'h0;
            MGMT_SERIAL_CLOCK_OE_O <= clk_oe_sel & running;
            MGMT_SERIAL_LINE_OE_O <= line_oe_sel & running;
            TARGET_CLOCK_O <= is_bridge | MGMT_SERIAL_CLOCK_I; // see R6
            TARGET_LINE_O <= is_bridge | MGMT_SERIAL_LINE_I;
            BRIDGE_CLOCK_O <= ~is_bridge | MGMT_SERIAL_CLOCK_I; // see R6
            BRIDGE_LINE_O <= ~is_bridge | MGMT_SERIAL_LINE_I;
            MGMT_ROLE_O <= role_r;
        end
    end

    // ==========================================
    // checks
    localparam int IND_LAT = `IND_LATENCY;

    sequence s_take;
        strap_take ##1 running;
    endsequence

    sequence s_bridge_cycle;
        running && is_bridge;
    endsequence

    sequence s_target_cycle;
        running && !is_bridge;
    endsequence

    chk_strap_latch: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R8
        s_take |-> role_r == $past(MGMT_ROLE_STRAP_I))
        else $error("strap not latched at reset release");
    chk_role_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R8
        running && $past(running) |-> $stable(role_r))
        else $error("role changed while running");
    chk_rate_float: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R1
        running && PORT_RATE_I[1:0] == `SPEED_NONE |=> !PORT_LINK_RATE_FLAG_OE_O[0])
        else $error("port 1 rate flag driven while unattached");
    chk_rate_gen1: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R1
        running && PORT_RATE_I[3:2] == `SPEED_SS
        |=> PORT_LINK_RATE_FLAG_OE_O[1] && PORT_LINK_RATE_FLAG_O[1])
        else $error("gen1 port not flagged high");
    chk_charge_flag: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R2
        running && PORT_CHARGE_EN_I[0]
        |=> PORT_CHARGE_FLAG_OE_O[0] && PORT_CHARGE_FLAG_O[0] == !$past(PORT_CHARGE_DONE_I[0]))
        else $error("charge flag wrong");
    chk_charge_float: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R3
        !PORT_CHARGE_EN_I[5] |=> !PORT_CHARGE_FLAG_OE_O[5])
        else $error("charge flag driven while disabled");
    chk_host_flag: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R4
        running && HOST_RATE_I == `SPEED_SS |=> HOST_LINK_FLAG_OE_O && !HOST_LINK_FLAG_O)
        else $error("host gen1 link not flagged low");
    chk_reset_mode: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R5
        strap_take |=> HUB_IN_RESET_O ##1 !HUB_IN_RESET_O)
        else $error("reset mode not left after release");
    chk_mgmt_route: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R6
        running && is_bridge |=> MGMT_SERIAL_LINE_OE_O == $past(BRIDGE_LINE_OE_I))
        else $error("bridge not routed to line");
    chk_suspend: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R7
        running && SUSPEND_I |-> ##[1:IND_LAT] SUSPEND_WAKE_FLAG_O)
        else $error("suspend flag late");
    chk_suspend_clear: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R7
        running && !SUSPEND_I |=> !SUSPEND_WAKE_FLAG_O)
        else $error("suspend flag set while awake");
    chk_rate_legacy: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R1
        running && PORT_RATE_I[5:4] == `SPEED_FS_HS
        |=> PORT_LINK_RATE_FLAG_OE_O[2] && !PORT_LINK_RATE_FLAG_O[2])
        else $error("legacy port not flagged low");
    chk_rate_rsvd: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R1
        running && PORT_RATE_I[9:8] == `SPEED_RSVD
        |=> PORT_LINK_RATE_FLAG_OE_O[4] && !PORT_LINK_RATE_FLAG_O[4])
        else $error("unused rate code not driven low");
    chk_rate_idle: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R1
        running && PORT_RATE_I[11:10] == `SPEED_NONE |=> !PORT_LINK_RATE_FLAG_OE_O[5])
        else $error("port 6 rate flag driven while unattached");
    chk_charge_wait: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R2
        running && PORT_CHARGE_EN_I[3] && !PORT_CHARGE_DONE_I[3]
        |=> PORT_CHARGE_FLAG_OE_O[3] && PORT_CHARGE_FLAG_O[3])
        else $error("charge flag low before handshake");
    chk_host_float: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R4
        running && HOST_RATE_I == `SPEED_NONE |=> !HOST_LINK_FLAG_OE_O)
        else $error("host flag driven with no host");
    chk_host_legacy: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R4
        running && HOST_RATE_I == `SPEED_FS_HS |=> HOST_LINK_FLAG_OE_O && HOST_LINK_FLAG_O)
        else $error("host legacy link not flagged high");
    chk_host_rsvd: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R4
        running && HOST_RATE_I == `SPEED_RSVD |=> HOST_LINK_FLAG_OE_O && !HOST_LINK_FLAG_O)
        else $error("host unused code not driven low");
    chk_target_route: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R6
        s_target_cycle |=> MGMT_SERIAL_CLOCK_OE_O == $past(TARGET_CLOCK_OE_I) && BRIDGE_CLOCK_O)
        else $error("target not routed to clock");
    chk_bridge_level: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // see R6
        s_bridge_cycle |=> BRIDGE_LINE_O == $past(MGMT_SERIAL_LINE_I) && TARGET_LINE_O)
        else $error("bridge line level not passed");
endmodule : hub_port_status_indicators

// >>> verification/board_status_model.sv
`timescale 1ns/1ps
// ==========================================
// board side: pin levels seen off chip
module board_status_model (
    // indicator drivers
    input wire logic [5:0] rate_flag_i,
    input wire logic [5:0] rate_oe_i,
    input wire logic [5:0] chg_flag_i,
    input wire logic [5:0] chg_oe_i,
    input wire logic host_flag_i,
    input wire logic host_oe_i,
    // open-drain management pins
    input wire logic clk_oe_i,
    input wire logic line_oe_i,
    input wire logic ext_clk_low_i,
    input wire logic ext_line_low_i,
    // resolved levels
    output logic [5:0] rate_pin_o,
    output logic [5:0] chg_pin_o,
    output logic host_pin_o,
    output logic clk_wire_o,
    output logic line_wire_o
);
    // undriven indicator pins have no pull, so they float
    for (genvar i = 0; i < 6; i++) begin : g_pin
        assign rate_pin_o[i] = rate_oe_i[i] ? rate_flag_i[i] : 1'bz;
        assign chg_pin_o[i] = chg_oe_i[i] ? chg_flag_i[i] : 1'bz;
    end
    assign host_pin_o = host_oe_i ? host_flag_i : 1'bz;
    // pull-up: high unless someone pulls low
    assign clk_wire_o = !(clk_oe_i || ext_clk_low_i);
    assign line_wire_o = !(line_oe_i || ext_line_low_i);
endmodule : board_status_model

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    import hub_ind_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, susp = 1'b0, strap = 1'b0;
    logic toe_c = 1'b0, toe_l = 1'b0, boe_c = 1'b0, boe_l = 1'b0, ext_c = 1'b0, ext_l = 1'b0;
    logic [11:0] rate = 12'h000;
    logic [5:0] en = 6'h00, done = 6'h00, rf, rfe, cf, cfe, rpin, cpin;
    logic [1:0] host = 2'h0;
    logic hf, hfe, sf, inrst, coe, loe, wc, wl, tc, tl, bc, bl, hpin, sc, sl;
    mgmt_role_t role;
    int err_total = 0, tests_run = 0;
    always #4 clk_sys = ~clk_sys;
    hub_port_status_indicators i_hub_port_status_indicators (.CLK_SYS_I(clk_sys), .RST_N_I(rst_n),
        .PORT_RATE_I(rate), .PORT_CHARGE_EN_I(en), .PORT_CHARGE_DONE_I(done), .HOST_RATE_I(host),
        .SUSPEND_I(susp), .MGMT_ROLE_STRAP_I(strap), .MGMT_SERIAL_CLOCK_I(wc),
        .MGMT_SERIAL_LINE_I(wl), .TARGET_CLOCK_OE_I(toe_c), .TARGET_LINE_OE_I(toe_l),
        .BRIDGE_CLOCK_OE_I(boe_c), .BRIDGE_LINE_OE_I(boe_l), .MGMT_SERIAL_CLOCK_O(sc),
        .MGMT_SERIAL_CLOCK_OE_O(coe), .MGMT_SERIAL_LINE_O(sl), .MGMT_SERIAL_LINE_OE_O(loe),
        .TARGET_CLOCK_O(tc), .TARGET_LINE_O(tl), .BRIDGE_CLOCK_O(bc), .BRIDGE_LINE_O(bl),
        .MGMT_ROLE_O(role), .PORT_LINK_RATE_FLAG_O(rf), .PORT_LINK_RATE_FLAG_OE_O(rfe),
        .PORT_CHARGE_FLAG_O(cf), .PORT_CHARGE_FLAG_OE_O(cfe), .HOST_LINK_FLAG_O(hf),
        .HOST_LINK_FLAG_OE_O(hfe), .SUSPEND_WAKE_FLAG_O(sf), .HUB_IN_RESET_O(inrst));
    board_status_model i_board_status_model (.rate_flag_i(rf), .rate_oe_i(rfe), .chg_flag_i(cf),
        .chg_oe_i(cfe), .host_flag_i(hf), .host_oe_i(hfe), .clk_oe_i(coe), .line_oe_i(loe),
        .ext_clk_low_i(ext_c), .ext_line_low_i(ext_l), .rate_pin_o(rpin), .chg_pin_o(cpin),
        .host_pin_o(hpin), .clk_wire_o(wc), .line_wire_o(wl));
    // ==========================================
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task automatic chk(input logic [5:0] got, input logic [5:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    // ==========================================
    // scenarios
    task automatic t_reset(input logic s);
        strap = s;
        rst_n = 1'b0;
        cyc(3);
        chk(inrst, 6'h01);
        chk(rfe | cfe, 6'h00);
        rst_n = 1'b1;
        cyc(2);
        chk(inrst, 6'h00);
    endtask : t_reset
    task automatic t_speed;
        for (int c = 0; c < 4; c++) begin
            rate = {6{c[1:0]}};
            cyc(2);
            chk(rpin, c == 0 ? 6'hzz : (c == 2 ? 6'h3f : 6'h00));
        end
        rate = 12'h924;
        cyc(2);
        chk(rpin, 6'b10z10z);
    endtask : t_speed
    task automatic t_charge;
        en = 6'h0f;
        done = 6'h05;
        cyc(2);
        chk(cpin, 6'bzz1010);
        en = 6'h00;
        done = 6'h3f;
        cyc(2);
        chk(cpin, 6'hzz);
    endtask : t_charge
    task automatic t_host_susp;
        for (int c = 0; c < 4; c++) begin
            host = c[1:0];
            susp = c[0];
            cyc(2);
            chk(hpin, c == 0 ? 6'b00000z : (c == 1 ? 6'h01 : 6'h00));
            chk(sf, {5'h00, c[0]});
        end
    endtask : t_host_susp
    task automatic t_mgmt;
        t_reset(1'b1);
        chk(role, ROLE_BRIDGE);
        boe_c = 1'b1;
        toe_l = 1'b1;
        cyc(3);
        chk({coe, loe, wc, wl, tc, bc}, 6'b100110);
        ext_l = 1'b1;
        strap = 1'b0;
        cyc(3);
        chk(role, ROLE_BRIDGE);
        chk({sc, sl, tl, bl, wl, 1'b0}, 6'h08);
        t_reset(1'b0);
        boe_c = 1'b0;
        ext_c = 1'b1;
        cyc(3);
        chk({coe, loe, tc, tl, bc, bl}, 6'b010011);
    endtask : t_mgmt
    initial begin
        #20000;
        err_total++;
        test_done;
    end
    initial begin
        t_reset(1'b0);
        t_speed;
        t_charge;
        t_host_susp;
        t_mgmt;
        test_done;
    end
endmodule : testbench
